// ---- sfe_event_control.sv ----
// Control side of the sensor sample FIFO: tagging, flush, interrupts,
// overflow policy and byte readout. Assumes all inputs except resetn are synchronous
// to clk and that the host drives one read strobe per byte.
`timescale 1ns/100ps
`default_nettype none

module sfe_event_control (
    input  wire logic        clk,               // Core clock
    input  wire logic        resetn,            // Async reset, low
    input  wire logic        frameValid,        // Sensor frame offered
    input  wire logic [15:0] frameData,         // Sensor sample
    output logic             frameReady,        // Frame path has room
    input  wire logic        headerMode,        // Framing with headers
    input  wire logic        stopOnFull,        // Keep oldest on full
    input  wire logic [3:0]  auxBytes,          // Aux bytes per frame
    input  wire logic [2:0]  sensorEnables,     // Sensors in FIFO
    input  wire logic [4:0]  watermark,         // Watermark in frames
    input  wire logic        tagPinAEnable,     // Tag from pin A
    input  wire logic        tagPinBEnable,     // Tag from pin B
    input  wire logic        pinAInputEnable,   // Pin A as input
    input  wire logic        pinBInputEnable,   // Pin B as input
    input  wire logic        interruptPinAIn,   // Pin A level
    input  wire logic        interruptPinBIn,   // Pin B level
    input  wire logic        mapFullPinA,       // Full onto pin A
    input  wire logic        mapFullPinB,       // Full onto pin B
    input  wire logic        mapWatermarkPinA,  // Watermark onto pin A
    input  wire logic        mapWatermarkPinB,  // Watermark onto pin B
    input  wire logic        selfWakeup,        // Flagged burst allowed
    input  wire logic        advPowerSave,      // Advanced power save
    input  wire logic        cmdWrite,          // Command byte strobe
    input  wire logic [7:0]  cmdData,           // Command byte
    input  wire logic        statusRead,        // Status read strobe
    input  wire logic        errorRead,         // Error read strobe
    input  wire logic        readBurst,         // Data burst open
    input  wire logic        readStrobe,        // One data byte
    output logic [7:0]       readData,          // Returned byte
    output logic             readValid,         // Byte returned
    output logic [4:0]       fillLevel,         // Frames stored
    output logic             fullStatus,        // Latched full
    output logic             watermarkStatus,   // Latched watermark
    output logic             fifoError,         // Lost new data
    output logic             interruptPinAOut,  // Pin A drive level
    output logic             interruptPinAOe,   // Pin A driven
    output logic             interruptPinBOut,  // Pin B drive level
    output logic             interruptPinBOe    // Pin B driven
);

    // Pointer step with wrap
    function automatic logic [sfe_pkg::PTR_W-1:0] ptrInc(
        input logic [sfe_pkg::PTR_W-1:0] p);
        ptrInc = p + 1'b1;
    endfunction

    // Index of last byte of a frame
    function automatic logic [1:0] lastIdx(input logic hdr);
        lastIdx = hdr ? 2'h2 : 2'h1;
    endfunction

    logic [sfe_pkg::WORD_W-1:0] mem_reg [sfe_pkg::DEPTH_INT]; // Frames
    logic [sfe_pkg::WORD_W-1:0] memNext [sfe_pkg::DEPTH_INT];
    logic [sfe_pkg::PTR_W-1:0]  wrPtr_reg, wrPtr_next;   // Write slot
    logic [sfe_pkg::PTR_W-1:0]  rdPtr_reg, rdPtr_next;   // Oldest slot
    logic [sfe_pkg::CNT_W-1:0]  count_reg, count_next;   // Fill level
    logic [1:0]                 cursor_reg, cursor_next; // Byte in frame
    logic                       ovrOdd_reg, ovrOdd_next; // Overread half
    sfe_pkg::sfe_rd_state_type  rdState_reg, rdState_next;
    logic [7:0]                 data_reg, data_next;     // Read byte
    logic                       valid_reg, valid_next;
    logic                       full_reg, full_next;     // Latched full
    logic                       wm_reg, wm_next;         // Latched wm
    logic                       err_reg, err_next;       // Data lost
    logic                       pinA_reg, pinA_next;
    logic                       pinB_reg, pinB_next;
    logic                       oeA_reg, oeB_reg;
    logic                       prevHdr_reg;             // Last framing
    logic [3:0]                 prevAux_reg;             // Last aux size
    logic [2:0]                 prevEn_reg;              // Last enables
    logic [sfe_pkg::WORD_W-1:0] tagWord;                 // Tagged frame
    logic                       tagOn;
    logic                       bufValid, bufReady;
    logic [sfe_pkg::WORD_W-1:0] bufData;
    logic                       flush, autoFlush;
    logic                       push, popRead, dropOld, dropNew;
    logic [sfe_pkg::WORD_W-1:0] head;

    // Tag frames on entry; power mode plays no part here
    always_comb begin
        tagOn   = tagPinAEnable && tagPinBEnable &&
                  pinAInputEnable && pinBInputEnable;
        tagWord = {tagOn ? {interruptPinBIn, interruptPinAIn}
                         : sfe_pkg::EXT_NONE, frameData};
    end

    // Frame path buffer; a full buffer stalls the source
    sfe_skid_buffer u_buffer (
        .clk      (clk),
        .resetn   (resetn),
        .inValid  (frameValid),
        .inData   (tagWord),
        .inReady  (frameReady),
        .outValid (bufValid),
        .outData  (bufData),
        .outReady (bufReady)
    );

    // Flush sources
    always_comb begin
        autoFlush = (headerMode != prevHdr_reg) ||
                    (auxBytes != prevAux_reg) ||
                    (!headerMode && sensorEnables != prevEn_reg);
        flush     = autoFlush ||
                    (cmdWrite && cmdData == sfe_pkg::CMD_FLUSH);
    end

    // Storage pointers, overflow policy and readout
    always_comb begin
        head         = mem_reg[rdPtr_reg];
        wrPtr_next   = wrPtr_reg;
        rdPtr_next   = rdPtr_reg;
        count_next   = count_reg;
        cursor_next  = cursor_reg;
        ovrOdd_next  = ovrOdd_reg;
        rdState_next = rdState_reg;
        data_next    = data_reg;
        valid_next   = 1'b0;
        popRead      = 1'b0;
        // No drop of the oldest frame during a burst: stall instead
        bufReady = !(count_reg == sfe_pkg::DEPTH && !stopOnFull &&
                     rdState_reg != sfe_pkg::RD_IDLE);
        push     = bufValid && bufReady && !flush;
        dropNew  = push && count_reg == sfe_pkg::DEPTH && stopOnFull;
        dropOld  = push && count_reg == sfe_pkg::DEPTH && !stopOnFull;
        // Burst admission decided once at burst start
        case (rdState_reg)
            sfe_pkg::RD_IDLE: begin
                cursor_next = 2'h0;
                ovrOdd_next = 1'b0;
                if (readBurst) begin
                    if (!advPowerSave || (selfWakeup && (full_reg || wm_reg)))
                        rdState_next = sfe_pkg::RD_GRANTED;
                    else
                        rdState_next = sfe_pkg::RD_DENIED;
                end
            end
            sfe_pkg::RD_GRANTED, sfe_pkg::RD_DENIED: begin
                if (!readBurst) begin
                    rdState_next = sfe_pkg::RD_IDLE;
                    cursor_next  = 2'h0; // Partial frame repeats
                end else if (readStrobe) begin
                    valid_next = 1'b1;
                    if (rdState_reg == sfe_pkg::RD_GRANTED &&
                        count_reg != 5'h0) begin
                        // Header, then sample low, then high
                        if (headerMode && cursor_reg == 2'h0)
                            data_next = sfe_pkg::HDR_REGULAR |
                                        {6'h00, head[17:16]};
                        else if (cursor_reg == lastIdx(headerMode))
                            data_next = head[15:8];
                        else
                            data_next = head[7:0];
                        if (cursor_reg == lastIdx(headerMode)) begin
                            cursor_next = 2'h0;
                            popRead     = 1'b1; // Whole frame read
                        end else begin
                            cursor_next = cursor_reg + 2'h1;
                        end
                    end else if (headerMode) begin
                        data_next = sfe_pkg::HDR_INVALID;
                    end else begin
                        data_next   = ovrOdd_reg ? sfe_pkg::OVR_HIGH
                                                 : sfe_pkg::OVR_LOW;
                        ovrOdd_next = !ovrOdd_reg;
                    end
                end
            end
            default: rdState_next = sfe_pkg::RD_IDLE;
        endcase
        // Store new frame; on full drop newest or oldest
        if (push && !dropNew) begin
            wrPtr_next = ptrInc(wrPtr_reg);
        end
        if (popRead || dropOld) begin
            rdPtr_next = ptrInc(rdPtr_reg);
        end
        count_next = count_reg + {4'h0, push && !dropNew}
                               - {4'h0, popRead || dropOld};
        if (flush) begin
            wrPtr_next  = '0;
            rdPtr_next  = '0;
            count_next  = '0;
            cursor_next = 2'h0;
        end
    end

    // Frame storage write
    always_comb begin
        memNext = mem_reg;
        if (push && !dropNew)
            memNext[wrPtr_reg] = bufData;
    end

    // Interrupt latches, error flag and pin drive
    always_comb begin
        // Set wins; clear needs status read and low fill
        full_next = (count_reg > sfe_pkg::FULL_THRESH) ? 1'b1 :
                    (statusRead ? 1'b0 : full_reg);
        wm_next   = (count_reg >= watermark) ? 1'b1 :
                    (statusRead ? 1'b0 : wm_reg);
        err_next  = (dropNew || (frameValid && !frameReady)) ? 1'b1 :
                    (errorRead ? 1'b0 : err_reg);
        pinA_next = (mapFullPinA && full_reg) ||
                    (mapWatermarkPinA && wm_reg);
        pinB_next = (mapFullPinB && full_reg) ||
                    (mapWatermarkPinB && wm_reg);
    end

    // Register stage for control state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg   <= '0;
            rdPtr_reg   <= '0;
            count_reg   <= '0;
            cursor_reg  <= 2'h0;
            ovrOdd_reg  <= 1'b0;
            rdState_reg <= sfe_pkg::RD_IDLE;
            data_reg    <= 8'h00;
            valid_reg   <= 1'b0;
            full_reg    <= 1'b0;
            wm_reg      <= 1'b0;
            err_reg     <= 1'b0;
            pinA_reg    <= 1'b0;
            pinB_reg    <= 1'b0;
            oeA_reg     <= 1'b0;
            oeB_reg     <= 1'b0;
            prevHdr_reg <= 1'b0;
            prevAux_reg <= 4'h0;
            prevEn_reg  <= 3'h0;
        end else begin
            wrPtr_reg   <= wrPtr_next;
            rdPtr_reg   <= rdPtr_next;
            count_reg   <= count_next;
            cursor_reg  <= cursor_next;
            ovrOdd_reg  <= ovrOdd_next;
            rdState_reg <= rdState_next;
            data_reg    <= data_next;
            valid_reg   <= valid_next;
            full_reg    <= full_next;
            wm_reg      <= wm_next;
            err_reg     <= err_next;
            pinA_reg    <= pinA_next;
            pinB_reg    <= pinB_next;
            oeA_reg     <= !pinAInputEnable;
            oeB_reg     <= !pinBInputEnable;
            prevHdr_reg <= headerMode;
            prevAux_reg <= auxBytes;
            prevEn_reg  <= sensorEnables;
        end
    end

    // Frame storage, no reset needed
    always_ff @(posedge clk) begin
        mem_reg <= memNext;
    end

    assign readData         = data_reg;
    assign readValid        = valid_reg;
    assign fillLevel        = count_reg;
    assign fullStatus       = full_reg;
    assign watermarkStatus  = wm_reg;
    assign fifoError        = err_reg;
    assign interruptPinAOut = pinA_reg;
    assign interruptPinAOe  = oeA_reg;
    assign interruptPinBOut = pinB_reg;
    assign interruptPinBOe  = oeB_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_tag_off;
        frameValid && !(tagPinAEnable && tagPinBEnable &&
            pinAInputEnable && pinBInputEnable) |->
            tagWord[17:16] == sfe_pkg::EXT_NONE;
    endproperty
    a_tag_off: assert property (p_tag_off)
        else $error("tag set while disabled");

    property p_full;
        fillLevel >= 5'h0E |=>
            fullStatus ##1 (fullStatus || $past(statusRead));
    endproperty
    a_full: assert property (p_full)
        else $error("full flag missing");

    property p_wm;
        fillLevel >= watermark && $stable(watermark) |=> watermarkStatus;
    endproperty
    a_wm: assert property (p_wm)
        else $error("watermark flag missing");

    property p_unmapped;
        !mapFullPinA && !mapWatermarkPinA |=> !interruptPinAOut;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped flag on pin");

    property p_hold;
        fullStatus && !statusRead |=> fullStatus;
    endproperty
    a_hold: assert property (p_hold)
        else $error("full cleared without read");

    property p_cmd_flush;
        cmdWrite && cmdData == 8'hB0 |=> fillLevel == 5'h00;
    endproperty
    a_cmd_flush: assert property (p_cmd_flush)
        else $error("flush left data");

    property p_mode_flush;
        headerMode != $past(headerMode) |=> fillLevel == 5'h00;
    endproperty
    a_mode_flush: assert property (p_mode_flush)
        else $error("mode change kept data");

    property p_aux_flush;
        auxBytes != $past(auxBytes) |=> fillLevel == 5'h00;
    endproperty
    a_aux_flush: assert property (p_aux_flush)
        else $error("aux change kept data");

    property p_en_flush;
        !headerMode && sensorEnables != $past(sensorEnables) |=>
            fillLevel == 5'h00;
    endproperty
    a_en_flush: assert property (p_en_flush)
        else $error("enable change kept data");

    property p_overread;
        readBurst && readStrobe && headerMode && fillLevel == 5'h00 &&
            rdState_reg != sfe_pkg::RD_IDLE |=>
            readValid && readData == 8'h80;
    endproperty
    a_overread: assert property (p_overread)
        else $error("bad overread marker");

    property p_lost;
        frameValid && !frameReady |=> fifoError;
    endproperty
    a_lost: assert property (p_lost)
        else $error("lost frame not flagged");

    c_full:   cover property (fullStatus && interruptPinAOut);
    c_over:   cover property (readValid && readData == 8'h80);
    c_stall:  cover property (frameValid && !frameReady);
    c_denied: cover property (rdState_reg == sfe_pkg::RD_DENIED);

endmodule

`default_nettype wire

// ---- sfe_event_control_tb_top.sv ----
// Self-checking bench for the sensor FIFO event control block.
// Assumes the host model and the shared package are compiled first.
`timescale 1ns/100ps
`default_nettype none

module sfe_event_control_tb_top;
    logic        clk, resetn, frameValid, frameReady, headerMode, stopOnFull;
    logic        tagPinAEnable, tagPinBEnable, pinAInputEnable;
    logic        pinBInputEnable, interruptPinAIn, interruptPinBIn;
    logic        mapFullPinA, mapFullPinB, mapWatermarkPinA, mapWatermarkPinB;
    logic        selfWakeup, advPowerSave, cmdWrite, statusRead, errorRead;
    logic        readBurst, readStrobe, readValid, fullStatus, fifoError;
    logic        watermarkStatus, interruptPinAOut, interruptPinAOe;
    logic        interruptPinBOut, interruptPinBOe;
    logic [15:0] frameData;
    logic [3:0]  auxBytes;
    logic [2:0]  sensorEnables;
    logic [4:0]  watermark, fillLevel;
    logic [7:0]  cmdData, readData;
    logic [31:0] lfsrReg;     // Random source
    logic [7:0]  expQ[$];     // Expected bytes
    logic [17:0] stq[$];      // Stored frames, tag and sample
    int          num_errors, n_compared;

    sfe_event_control dut (.clk, .resetn, .frameValid, .frameData,
        .frameReady, .headerMode, .stopOnFull, .auxBytes, .sensorEnables,
        .watermark, .tagPinAEnable, .tagPinBEnable, .pinAInputEnable,
        .pinBInputEnable, .interruptPinAIn, .interruptPinBIn, .mapFullPinA,
        .mapFullPinB, .mapWatermarkPinA, .mapWatermarkPinB, .selfWakeup,
        .advPowerSave, .cmdWrite, .cmdData, .statusRead, .errorRead,
        .readBurst, .readStrobe, .readData, .readValid, .fillLevel,
        .fullStatus, .watermarkStatus, .fifoError, .interruptPinAOut,
        .interruptPinAOe, .interruptPinBOut, .interruptPinBOe);
    sfe_host_model host (.clk, .readBurst, .readStrobe);

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk) #1;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge clk) #1;
        s = 1'b0;
    endtask

    // Offer one random frame; pins held whole cycles
    task automatic push;
        int k;
        lfsrReg = lfsr(lfsrReg);
        frameData = lfsrReg[15:0];
        {interruptPinBIn, interruptPinAIn} = lfsrReg[17:16];
        frameValid = 1'b1;
        k = 0;
        while (frameReady !== 1'b1 && k < 50) begin
            @(posedge clk) #1;
            k++;
        end
        if (k == 50) begin
            num_errors++;
            summarize();
        end
        @(posedge clk) #1;
        frameValid = 1'b0;
        @(posedge clk) #1;
        if (!stopOnFull && stq.size() == sfe_pkg::DEPTH_INT)
            void'(stq.pop_front()); // Oldest dropped
        if (stq.size() < sfe_pkg::DEPTH_INT) // Newest dropped
            stq.push_back({(tagPinAEnable & tagPinBEnable & pinAInputEnable
                & pinBInputEnable) ? lfsrReg[17:16] : 2'h0, frameData});
    endtask

    // Note the bytes a burst of n strobes returns, then run it
    task automatic rd(input int n, input int gap, input bit grant);
        logic [17:0] f;
        int          b, j;
        bit          m;
        b = 0;
        m = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (grant && stq.size() > 0) begin
                f = stq[0];
                j = headerMode ? b : b + 1;
                expQ.push_back(j == 0 ? sfe_pkg::HDR_REGULAR | {6'h0,
                    f[17:16]} : j == 1 ? f[7:0] : f[15:8]);
                b++;
                if (b == (headerMode ? 3 : 2)) begin
                    void'(stq.pop_front());
                    b = 0;
                end
            end else begin
                expQ.push_back(headerMode ? sfe_pkg::HDR_INVALID
                    : m ? sfe_pkg::OVR_HIGH : sfe_pkg::OVR_LOW);
                m = !m;
            end
        end
        host.burst(n, gap);
        check("bytes left", expQ.size(), 0);
    endtask

    // Compare each returned byte against the oldest note
    always @(negedge clk) begin
        if (readValid === 1'b1)
            check("read byte", readData,
                expQ.size() > 0 ? expQ.pop_front() : 8'hxx);
    end

    // Main sequence
    initial begin
        lfsrReg = 32'h7c7b;
        num_errors = 0;
        n_compared = 0;
        {resetn, frameValid, frameData, cmdData} = 26'h0;
        {headerMode, stopOnFull, tagPinAEnable, tagPinBEnable} = 4'hF;
        {pinAInputEnable, pinBInputEnable, interruptPinAIn} = 3'h6;
        {interruptPinBIn, mapFullPinA, mapFullPinB, mapWatermarkPinA} = 4'h3;
        {mapWatermarkPinB, selfWakeup, advPowerSave, cmdWrite} = 4'h0;
        {statusRead, errorRead, auxBytes, sensorEnables} = 9'h007;
        watermark = 5'h04;
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        idle(3);
        rd(2, 0, 1);
        for (int i = 1; i <= 17; i++) begin
            tagPinBEnable = (i != 2);
            push();
            idle(4);
            check("watermark", watermarkStatus, i >= 4);
            check("full", fullStatus, i >= 14);
            check("pin a", interruptPinAOut, i >= 4);
            check("pin b", interruptPinBOut, i >= 14);
            check("error", fifoError, i >= 17);
            check("fill", fillLevel, i > 16 ? 16 : i);
        end
        {mapWatermarkPinA, mapFullPinB} = 2'h0;
        idle(2);
        check("pin a", interruptPinAOut, 0);
        check("pin b", interruptPinBOut, 0);
        {mapWatermarkPinA, mapFullPinB} = 2'h3;
        pulse(errorRead);
        pulse(statusRead);
        idle(2);
        check("error clear", fifoError, 0);
        check("full held", fullStatus, 1);
        {stopOnFull, advPowerSave} = 2'h1;
        fork
            rd(2, 6, 0);
            begin
                idle(2);
                repeat (3) push();
            end
        join
        advPowerSave = 1'b0;
        idle(3);
        check("stall", fifoError, 1);
        check("fill", fillLevel, 16);
        rd(2, 0, 1);
        rd(3, 0, 1);
        idle(2);
        check("fill", fillLevel, 15);
        {advPowerSave, selfWakeup} = 2'h3;
        rd(46, 1, 1);
        idle(2);
        check("drained", fillLevel, 0);
        check("full kept", fullStatus, 1);
        pulse(statusRead);
        idle(2);
        check("full clear", fullStatus, 0);
        check("wm clear", watermarkStatus, 0);
        push();
        rd(3, 0, 0);
        idle(2);
        check("denied", fillLevel, 1);
        advPowerSave = 1'b0;
        cmdData = 8'hB1;
        pulse(cmdWrite);
        idle(2);
        check("no flush", fillLevel, 1);
        cmdData = sfe_pkg::CMD_FLUSH;
        pulse(cmdWrite);
        stq.delete();
        push();
        idle(3);
        check("flushed", fillLevel, 1);
        rd(4, 0, 1);
        headerMode = 1'b0;
        idle(3);
        push();
        idle(3);
        rd(4, 0, 1);
        for (int i = 0; i < 5; i++) begin
            push();
            idle(2);
            case (i)
                0: sensorEnables = 3'h3;
                1: auxBytes = 4'h2;
                2: headerMode = 1'b1;
                3: sensorEnables = 3'h7;
                default: headerMode = 1'b0;
            endcase
            idle(3);
            check("auto flush", fillLevel, i == 3);
        end
        pinBInputEnable = 1'b0;
        idle(2);
        check("oe a", interruptPinAOe, 0);
        check("oe b", interruptPinBOe, 1);
        summarize();
    end
endmodule

`default_nettype wire

// ---- sfe_host_model.sv ----
// Host side model: opens a data burst and strobes bytes out of the FIFO.
// Assumes the bench notes expected bytes and compares them itself.
`timescale 1ns/100ps
`default_nettype none

module sfe_host_model (
    input  wire logic clk,        // Core clock
    output logic      readBurst,  // Burst open
    output logic      readStrobe  // One byte request
);
    // Idle bus at time zero
    initial begin
        readBurst  = 1'b0;
        readStrobe = 1'b0;
    end

    // One burst of n bytes; gap idle cycles make a slow host
    task automatic burst(input int n, input int gap);
        @(posedge clk) #1;
        readBurst = 1'b1;
        @(posedge clk) #1;
        for (int i = 0; i < n; i++) begin
            readStrobe = 1'b1;
            @(posedge clk) #1;
            if (gap > 0) begin
                readStrobe = 1'b0;
                repeat (gap) @(posedge clk) #1;
            end
        end
        readStrobe = 1'b0;
        repeat (2) @(posedge clk) #1;
        readBurst = 1'b0;
        @(posedge clk) #1;
    endtask
endmodule

`default_nettype wire

// ---- sfe_pkg.sv ----
// Constants shared by the sensor FIFO event control block.
// Assumes a single 10 MHz core clock and frame-wide storage.
`default_nettype none

package sfe_pkg;

    // Storage geometry
    localparam int          DEPTH_INT   = 16;        // Frames held
    localparam logic [4:0]  DEPTH       = 5'h10;     // Frames, count width
    localparam int          PTR_W       = 4;         // Pointer width
    localparam int          CNT_W       = 5;         // Fill level width
    localparam int          WORD_W      = 18;        // Tag plus sample
    localparam logic [4:0]  FULL_THRESH = 5'h0D;     // Full above this

    // Command and marker codes
    localparam logic [7:0]  CMD_FLUSH   = 8'hB0;     // Flush command
    localparam logic [7:0]  HDR_REGULAR = 8'h84;     // Regular frame header
    localparam logic [7:0]  HDR_INVALID = 8'h80;     // Overread, header mode
    localparam logic [7:0]  OVR_LOW     = 8'h00;     // Overread word, low
    localparam logic [7:0]  OVR_HIGH    = 8'h80;     // Overread word, high

    // Field positions and reset values
    localparam int          EXT_LSB     = 16;        // Tag bits in word
    localparam logic [1:0]  EXT_NONE    = 2'h0;      // Tag field cleared

    // Least level time on a tag pin, and its cycle count
    localparam int          CLK_NS      = 100;       // Core clock period
    localparam int          TAG_MIN_NS  = 10;        // Least active level
    localparam int          TAG_MIN_CYC =
        ((TAG_MIN_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
        (TAG_MIN_NS + CLK_NS - 1) / CLK_NS;          // Rounded up

    // Readout burst states
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_GRANTED,
        RD_DENIED
    } sfe_rd_state_type;

endpackage

`default_nettype wire

// ---- sfe_skid_buffer.sv ----
// Two-entry buffer between sensor sampling and frame storage.
// Assumes both sides use valid/ready on the same clock.
`timescale 1ns/100ps
`default_nettype none

module sfe_skid_buffer (
    input  wire logic                       clk,      // Core clock
    input  wire logic                       resetn,   // Async reset, low
    input  wire logic                       inValid,  // Word offered
    input  wire logic [sfe_pkg::WORD_W-1:0] inData,   // Offered word
    output logic                            inReady,  // Room for a word
    output logic                            outValid, // Word waiting
    output logic [sfe_pkg::WORD_W-1:0]      outData,  // Oldest word
    input  wire logic                       outReady  // Storage takes it
);

    logic [1:0]                      count_reg;   // Entries held
    logic [1:0]                      count_next;
    logic [sfe_pkg::WORD_W-1:0]      head_reg;    // Oldest entry
    logic [sfe_pkg::WORD_W-1:0]      head_next;
    logic [sfe_pkg::WORD_W-1:0]      tail_reg;    // Newer entry
    logic [sfe_pkg::WORD_W-1:0]      tail_next;
    logic                            ready_reg;   // Registered ready
    logic                            push;
    logic                            pop;

    assign inReady  = ready_reg;
    assign outValid = (count_reg != 2'h0);
    assign outData  = head_reg;

    // Entry shuffle on push and pop
    always_comb begin
        push       = inValid && ready_reg;
        pop        = outValid && outReady;
        count_next = count_reg;
        head_next  = head_reg;
        tail_next  = tail_reg;
        if (push && pop) begin
            if (count_reg == 2'h1) begin
                head_next = inData;
            end else begin
                head_next = tail_reg;
                tail_next = inData;
            end
        end else if (pop) begin
            head_next  = tail_reg;
            count_next = count_reg - 2'h1;
        end else if (push) begin
            if (count_reg == 2'h0) begin
                head_next = inData;
            end else begin
                tail_next = inData;
            end
            count_next = count_reg + 2'h1;
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 2'h0;
            head_reg  <= '0;
            tail_reg  <= '0;
            ready_reg <= 1'b1;
        end else begin
            count_reg <= count_next;
            head_reg  <= head_next;
            tail_reg  <= tail_next;
            ready_reg <= (count_next != 2'h2);
        end
    end

endmodule

`default_nettype wire
